// ### afsr_cmp_if.sv
// Interface carrying one channel's result and threshold comparison.
`timescale 1ns/100ps
interface afsr_cmp_if;
  import afsr_pkg::*;
  logic [RESULT_W-1:0] result;
  logic                valid;
  logic [THRESH_W-1:0] low_thr;
  logic [THRESH_W-1:0] high_thr;
  logic                over;
  logic                under;

  modport cmp (input result, input valid, input low_thr, input high_thr,
               output over, output under);
  modport user (output result, output valid, output low_thr, output high_thr,
                input over, input under);
endinterface : afsr_cmp_if

// ### afsr_host_model.sv
// Host controller model: register port master and converter event source.
`timescale 1ns/100ps
module afsr_host_model
  import afsr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic [REG_W-1:0]    rdata,
  output      logic [ADDR_W-1:0]   addr,
  output      logic [REG_W-1:0]    wdata,
  output      logic                wr_en,
  output      logic                rd_en,
  output      logic                chk_reject,
  output      logic                load_fail,
  output      logic                conv_valid,
  output      logic [RESULT_W-1:0] chan_b_result,
  output      logic [RESULT_W-1:0] chan_c_result,
  output      logic [RESULT_W-1:0] chan_d_result,
  output      logic [THRESH_W-1:0] alert_low_thr,
  output      logic [THRESH_W-1:0] alert_high_thr
);
  // Idle at time zero; the thresholds give limits 0x1000 and 0x800f.
  initial begin
    {addr, wdata, wr_en, rd_en, chk_reject, load_fail, conv_valid} = '0;
    {chan_b_result, chan_c_result, chan_d_result} = '0;
    alert_low_thr  = 12'h100;
    alert_high_thr = 12'h800;
  end

  // One-cycle write; reset codes for the control register go through here.
  task automatic write(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask : write

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic read(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : read

  // One-cycle event pulses; results are inverted afterwards so stale data never look valid.
  task automatic stim(input logic chk, input logic load, input logic cv, input logic [RESULT_W-1:0] b = 16'h4000,
                      input logic [RESULT_W-1:0] c = 16'h4000, input logic [RESULT_W-1:0] d = 16'h4000);
    @(posedge clk);
    chk_reject    <= chk;
    load_fail     <= load;
    conv_valid    <= cv;
    chan_b_result <= b;
    chan_c_result <= c;
    chan_d_result <= d;
    @(posedge clk);
    {chk_reject, load_fail, conv_valid} <= 3'h0;
    {chan_b_result, chan_c_result, chan_d_result} <= ~{b, c, d};
  endtask : stim
endmodule : afsr_host_model

// ### afsr_pkg.sv
// Constants and types shared by the alert and fault status block.
package afsr_pkg;

  // Bus and field widths.
  localparam int REG_W    = 16;
  localparam int ADDR_W   = 4;
  localparam int RESULT_W = 16;
  localparam int THRESH_W = 12;
  localparam int CHAN_N   = 3;
  localparam int ALERT_N  = 2 * CHAN_N;
  localparam int IRQ_W    = ALERT_N + 2;

  // Register addresses on the local port.
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_ISTAT  = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_IMASK  = 4'h9;

  // Reset field of the control register and its codes.
  localparam int RST_LSB = 0;
  localparam int RST_MSB = 7;
  localparam logic [7:0] SOFT_CODE = 8'h3c;
  localparam logic [7:0] HARD_CODE = 8'hff;

  // Padding of thresholds into full result width.
  localparam logic [3:0] LOW_PAD  = 4'h0;
  localparam logic [3:0] HIGH_PAD = 4'hf;

  // Interrupt bit positions; alerts sit above these two.
  localparam int IRQ_LOAD  = 0;
  localparam int IRQ_CHK   = 1;
  localparam int IRQ_ALERT = 2;

  // Reset values.
  localparam logic [REG_W-1:0] RDATA_RST = 16'h0000;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 8'h00;

  // Complete state of the top module.
  typedef struct packed {
    logic                chk_fault;
    logic                load_fault;
    logic [ALERT_N-1:0]  alerts;
    logic [IRQ_W-1:0]    istat;
    logic [IRQ_W-1:0]    imask;
    logic [REG_W-1:0]    rdata;
    logic                irq;
    logic                reload;
  } afsr_state_t;

endpackage : afsr_pkg

// ### afsr_thr_cmp.sv
// Threshold comparator for one converter channel.
`timescale 1ns/100ps
module afsr_thr_cmp
  import afsr_pkg::*;
(
  afsr_cmp_if.cmp port
);

  logic [RESULT_W-1:0] low_full;
  logic [RESULT_W-1:0] high_full;

  // Thresholds fill the top bits; the low end is padded so that a
  // result equal to the limit does not raise an alert.
  assign low_full  = {port.low_thr, LOW_PAD};
  assign high_full = {port.high_thr, HIGH_PAD};

  // Alerts are raised only for a fresh result.
  assign port.under = port.valid && (port.result < low_full);
  assign port.over  = port.valid && (port.result > high_full);

endmodule : afsr_thr_cmp

// ### afsr_top.sv
// Alert and fault status register bank with threshold alerts.
//
// Summary of operation
// - Status reads return the register's own address in bits 15:12, read only.
// - A write rejected for a bad checksum sets bit 9.
// - Bit 9 stays set until the host reads the status register or writes a soft or hard reset code.
// - A failed startup configuration load sets bit 8.
// - Reading the status register leaves bit 8 unchanged.
// - A hard reset clears bit 8 and restarts the configuration load.
// - Channel D result above the high threshold sets bit 7.
// - Channel D result below the low threshold sets bit 6.
// - Channel C result above the high threshold sets bit 5.
// - Channel C result below the low threshold sets bit 4.
// - Channel B result above the high threshold sets bit 3.
// - Channel B result below the low threshold sets bit 2.
// - Alert flags hold across conversions and clear only on a status read or a soft or hard reset code.
// - Low alert when result below low limit; high alert when above high limit.
// - Soft reset code clears all alert flags, leaving register contents.
// - Hard reset code returns every register to its default value.
`timescale 1ns/100ps
module afsr_top
  import afsr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [REG_W-1:0]    wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output      logic [REG_W-1:0]    rdata,
  input  wire logic                chk_reject,
  input  wire logic                load_fail,
  input  wire logic                conv_valid,
  input  wire logic [RESULT_W-1:0] chan_b_result,
  input  wire logic [RESULT_W-1:0] chan_c_result,
  input  wire logic [RESULT_W-1:0] chan_d_result,
  input  wire logic [THRESH_W-1:0] alert_low_thr,
  input  wire logic [THRESH_W-1:0] alert_high_thr,
  output      logic                config_reload,
  output      logic                irq
);

  // Sticky flag update; a set in the clearing cycle wins.
  function automatic logic sticky(input logic cur,
                                  input logic clr,
                                  input logic set);
    sticky = (cur & ~clr) | set;
  endfunction : sticky

  // Builds the status word from the stored flags.
  function automatic logic [REG_W-1:0] status_word(input afsr_state_t s);
    status_word = {ADDR_STATUS,
                   2'b00,
                   s.chk_fault,
                   s.load_fault,
                   s.alerts,
                   2'b00};
  endfunction : status_word

  afsr_state_t st;
  afsr_state_t next_st;

  logic [RESULT_W-1:0] results [CHAN_N];
  logic [ALERT_N-1:0]  raise;
  logic                rd_stat;
  logic                wr_ctrl;
  logic                soft_rst;
  logic                hard_rst;
  logic                clr_alert;
  logic [IRQ_W-1:0]    irq_set;
  logic [IRQ_W-1:0]    irq_clr;

  // Channel order B, C, D gives alert pairs at status bits 3:2, 5:4, 7:6.
  assign results[0] = chan_b_result;
  assign results[1] = chan_c_result;
  assign results[2] = chan_d_result;

  afsr_cmp_if cmp_if [CHAN_N] ();

  // One comparator per channel; the shared limits apply to all.
  for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
    assign cmp_if[i].result   = results[i];
    assign cmp_if[i].valid    = conv_valid;
    assign cmp_if[i].low_thr  = alert_low_thr;
    assign cmp_if[i].high_thr = alert_high_thr;
    assign raise[2*i]         = cmp_if[i].under;
    assign raise[2*i+1]       = cmp_if[i].over;

    afsr_thr_cmp u_cmp (
      .port (cmp_if[i])
    );
  end

  // Access decoding and the two reset codes.
  assign rd_stat   = rd_en && (addr == ADDR_STATUS);
  assign wr_ctrl   = wr_en && (addr == ADDR_CTRL);
  assign soft_rst  = wr_ctrl && (wdata[RST_MSB:RST_LSB] == SOFT_CODE);
  assign hard_rst  = wr_ctrl && (wdata[RST_MSB:RST_LSB] == HARD_CODE);
  assign clr_alert = rd_stat || soft_rst || hard_rst;

  // Interrupt events share the layout of the mask register.
  assign irq_set = {raise, chk_reject, load_fail};

  // Write one to clear; a hard reset clears everything.
  always_comb begin
    irq_clr = '0;
    if (hard_rst) begin
      irq_clr = '1;
    end else if (wr_en && (addr == ADDR_ISTAT)) begin
      irq_clr = wdata[IRQ_W-1:0];
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;

    // Checksum fault clears on a status read or either reset.
    next_st.chk_fault = sticky(st.chk_fault, clr_alert,
                               chk_reject);

    // Load fault ignores reads; only a hard reset clears it.
    next_st.load_fault = sticky(st.load_fault, hard_rst,
                                load_fail);

    // Alerts hold until read or reset.
    for (int i = 0; i < ALERT_N; i++) begin
      next_st.alerts[i] = sticky(st.alerts[i], clr_alert,
                                 raise[i]);
    end

    // Interrupt status, set winning over the write-one clear.
    for (int i = 0; i < IRQ_W; i++) begin
      next_st.istat[i] = sticky(st.istat[i], irq_clr[i], irq_set[i]);
    end

    // Mask register; the hard reset returns it to default.
    if (hard_rst) begin
      next_st.imask = IRQ_RST;
    end else if (wr_en && (addr == ADDR_IMASK)) begin
      next_st.imask = wdata[IRQ_W-1:0];
    end

    // Read data stand for one cycle only, zero otherwise.
    next_st.rdata = RDATA_RST;
    if (rd_en) begin
      if (addr == ADDR_STATUS) begin
        next_st.rdata = status_word(st);
      end else if (addr == ADDR_ISTAT) begin
        next_st.rdata = {{(REG_W-IRQ_W){1'b0}}, st.istat};
      end else if (addr == ADDR_IMASK) begin
        next_st.rdata = {{(REG_W-IRQ_W){1'b0}}, st.imask};
      end else begin
        next_st.rdata = RDATA_RST;
      end
    end

    // Restart the configuration load after a hard reset.
    next_st.reload = hard_rst;

    // Level interrupt from the next status, registered together with it.
    next_st.irq = |(next_st.istat & next_st.imask);
  end

  // All state in one register; every flag starts clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata         = st.rdata;
  assign config_reload = st.reload;
  assign irq           = st.irq;

  // Checks of the register behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Address field of every status read.
  addr_field_a : assert property (
    rd_stat |=> rdata[15:12] == ADDR_STATUS)
    else $error("status read lacks its address field");

  // Checksum reject sets the fault flag.
  chk_set_a : assert property (
    chk_reject ##1 rd_stat |=> rdata[9])
    else $error("checksum fault not reported");

  // Checksum fault holds until a clearing access.
  chk_hold_a : assert property (
    st.chk_fault && !clr_alert |=> st.chk_fault)
    else $error("checksum fault dropped without a read");

  // Checksum fault gone after a read without new event.
  chk_clr_a : assert property (
    rd_stat && !chk_reject |=> !st.chk_fault)
    else $error("checksum fault not cleared by read");

  // Load failure sets the load fault flag.
  load_set_a : assert property (
    load_fail |=> st.load_fault)
    else $error("load fault not set");

  // Status reads keep the load fault.
  load_keep_a : assert property (
    st.load_fault && rd_stat && !hard_rst |=> st.load_fault && rdata[8])
    else $error("load fault lost on read");

  // Hard reset clears the load fault and starts a reload.
  hard_clr_a : assert property (
    hard_rst && !load_fail |=> !st.load_fault && config_reload
                               ##1 !config_reload)
    else $error("hard reset did not clear and reload");

  // A raised alert shows on a status read issued in the following cycle.
  alert_set_a : assert property (
    |raise ##1 rd_stat |=> (rdata[7:2] & $past(raise, 2)) == $past(raise, 2))
    else $error("raised alert missing from status");

  // Alerts hold over later conversions.
  alert_hold_a : assert property (
    !clr_alert |=> (st.alerts & $past(st.alerts)) == $past(st.alerts))
    else $error("alert flag dropped without a read");

  // Soft reset clears alerts, keeping the mask and load fault.
  // A load failure in the same cycle may still set the load fault, so it is excluded.
  soft_clr_a : assert property (
    soft_rst && !(|raise) && !load_fail |=> st.alerts == '0 && $stable(st.imask)
                              && st.load_fault == $past(st.load_fault))
    else $error("soft reset mishandled");

  // Hard reset returns the mask to default.
  hard_mask_a : assert property (
    hard_rst |=> st.imask == IRQ_RST)
    else $error("mask not reset by hard reset");

  // Reserved bits 11:10 read zero on every status read.
  reserved_zero_a : assert property (
    rd_stat |=> rdata[11:10] == 2'b00)
    else $error("reserved bits not zero");

  // An event during its clearing read is kept.
  set_wins_a : assert property (
    chk_reject && rd_stat |=> st.chk_fault)
    else $error("event lost during clearing read");

  // Interrupt is registered together with the status, so both agree in every cycle.
  irq_level_a : assert property (
    irq == |(st.istat & st.imask))
    else $error("interrupt level wrong");

  // Main scenarios.
  alert_read_c : cover property (|raise ##[1:4] rd_stat ##1 |rdata[7:2]);
  hard_reload_c : cover property (st.load_fault ##1 hard_rst ##1 config_reload);
  race_c : cover property (chk_reject && rd_stat);
  irq_c : cover property (!irq ##1 irq ##[1:8] !irq);

endmodule : afsr_top

// ### tb.sv
// Self-checking testbench of the alert and fault status block.
`timescale 1ns/100ps
module tb
  import afsr_pkg::*;
;
  logic                clk = 1'b0;
  logic                reset_n;
  logic [ADDR_W-1:0]   addr;
  logic [REG_W-1:0]    wdata;
  logic                wr_en;
  logic                rd_en;
  logic [REG_W-1:0]    rdata;
  logic                chk_reject;
  logic                load_fail;
  logic                conv_valid;
  logic [RESULT_W-1:0] chan_b_result;
  logic [RESULT_W-1:0] chan_c_result;
  logic [RESULT_W-1:0] chan_d_result;
  logic [THRESH_W-1:0] alert_low_thr;
  logic [THRESH_W-1:0] alert_high_thr;
  logic                config_reload;
  logic                irq;
  logic [REG_W-1:0]    d;
  logic [RESULT_W-1:0] res [CHAN_N];
  int                  mismatches = 0;
  int                  compares = 0;
  int                  n;

  // 40 MHz clock.
  always #12.5 clk = ~clk;

  afsr_top afsr_top_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .chk_reject(chk_reject), .load_fail(load_fail), .conv_valid(conv_valid),
    .chan_b_result(chan_b_result), .chan_c_result(chan_c_result), .chan_d_result(chan_d_result),
    .alert_low_thr(alert_low_thr), .alert_high_thr(alert_high_thr), .config_reload(config_reload), .irq(irq));

  afsr_host_model afsr_host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .chk_reject(chk_reject), .load_fail(load_fail), .conv_valid(conv_valid),
    .chan_b_result(chan_b_result), .chan_c_result(chan_c_result), .chan_d_result(chan_d_result),
    .alert_low_thr(alert_low_thr), .alert_high_thr(alert_high_thr));

  // Expected status word: own address on top, reserved and channel A bits zero.
  function automatic logic [REG_W-1:0] stat(input logic chk, input logic load, input logic [5:0] al);
    return {ADDR_STATUS, 2'b00, chk, load, al, 2'b00};
  endfunction : stat

  task automatic cmp16(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : cmp16

  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0, got}, {15'h0, exp});
  endtask : cmp1

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
    afsr_host_model_i.read(a, d);
    cmp16(d, exp);
  endtask : rd

  // The interrupt is registered, so three cycles are ample for it to settle.
  task automatic irqchk(input logic exp);
    repeat (3) @(posedge clk);
    #1 cmp1(irq, exp);
  endtask : irqchk

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // Cuts a hang short.
  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    cmp1(irq, 1'b0);
    cmp1(config_reload, 1'b0);
    afsr_host_model_i.write(ADDR_STATUS, 16'hffff);
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    rd(4'h5, 16'h0000);
    rd(ADDR_CTRL, 16'h0000);
    // Results exactly at the limits raise nothing.
    afsr_host_model_i.stim(0, 0, 1, 16'h1000, 16'h800f, 16'h1000);
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    // Each channel under, then over; a later plain conversion must not clear the flag.
    for (int i = 0; i < CHAN_N; i++) begin
      for (int h = 0; h < 2; h++) begin
        res = '{16'h4000, 16'h4000, 16'h4000};
        res[i] = h ? 16'h8010 : 16'h0fff;
        afsr_host_model_i.stim(0, 0, 1, res[0], res[1], res[2]);
        afsr_host_model_i.stim(0, 0, 1);
        rd(ADDR_STATUS, stat(0, 0, 6'(1 << (2 * i + h))));
        rd(ADDR_STATUS, stat(0, 0, 6'h00));
      end
    end
    afsr_host_model_i.stim(1, 0, 0);
    rd(ADDR_STATUS, stat(1, 0, 6'h00));
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    // A read in the cycle right after the events must already report them.
    fork
      afsr_host_model_i.stim(1, 0, 1, 16'h0fff);
      begin
        @(posedge clk);
        afsr_host_model_i.read(ADDR_STATUS, d);
      end
    join
    cmp16(d, stat(1, 0, 6'h01));
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    afsr_host_model_i.stim(0, 1, 0);
    rd(ADDR_STATUS, stat(0, 1, 6'h00));
    rd(ADDR_STATUS, stat(0, 1, 6'h00));
    // Soft reset drops the checksum fault and alerts but keeps the load fault.
    afsr_host_model_i.stim(1, 0, 1, 16'h0fff, 16'h8010);
    afsr_host_model_i.write(ADDR_CTRL, {8'h00, SOFT_CODE});
    rd(ADDR_STATUS, stat(0, 1, 6'h00));
    // An event in the cycle of a clearing read must survive it.
    fork
      afsr_host_model_i.read(ADDR_STATUS, d);
      afsr_host_model_i.stim(1, 0, 0);
    join
    cmp16(d, stat(0, 1, 6'h00));
    rd(ADDR_STATUS, stat(1, 1, 6'h00));
    // Interrupt: clear, mask, raise, clear again.
    afsr_host_model_i.write(ADDR_ISTAT, 16'h00ff);
    irqchk(1'b0);
    afsr_host_model_i.write(ADDR_IMASK, 16'h0080);
    rd(ADDR_IMASK, 16'h0080);
    afsr_host_model_i.stim(1, 0, 0);
    irqchk(1'b0);
    afsr_host_model_i.stim(0, 0, 1, 16'h4000, 16'h4000, 16'h8010);
    irqchk(1'b1);
    rd(ADDR_ISTAT, 16'h0082);
    afsr_host_model_i.write(ADDR_ISTAT, 16'h0080);
    irqchk(1'b0);
    rd(ADDR_ISTAT, 16'h0002);
    // Hard reset: one reload pulse, every flag and register back to default.
    afsr_host_model_i.write(ADDR_CTRL, {8'h00, HARD_CODE});
    n = 0;
    repeat (4) begin
      #1;
      if (config_reload === 1'b1) n++;
      @(posedge clk);
    end
    cmp1(n == 1, 1'b1);
    rd(ADDR_STATUS, stat(0, 0, 6'h00));
    rd(ADDR_IMASK, 16'h0000);
    rd(ADDR_ISTAT, 16'h0000);
    results();
  end
endmodule : tb
